// [inc/mttr_pkg.sv]
// Package: offsets, field layout and reset values of the tag report bank
package mttr_pkg;
    // ****************************************************************
    // Register offsets (byte addresses)
    // ****************************************************************
    localparam logic [11:0] OFF_FIRST_XY = 12'h128;
    localparam logic [11:0] OFF_FIRST_TAG = 12'h12c;
    localparam logic [11:0] OFF_SECOND_XY = 12'h130;
    localparam logic [11:0] OFF_SECOND_TAG = 12'h134;
    localparam logic [11:0] OFF_THIRD_XY = 12'h138;
    localparam logic [11:0] OFF_THIRD_TAG = 12'h13c;
    localparam logic [11:0] OFF_FOURTH_XY = 12'h140;
    localparam logic [11:0] OFF_FOURTH_TAG = 12'h144;
    localparam logic [11:0] OFF_FIFTH_XY = 12'h148;
    localparam logic [11:0] OFF_FIFTH_TAG = 12'h14c;
    // ****************************************************************
    // Field layout and reset values
    // ****************************************************************
    localparam int TAG_W = 8;
    localparam int COORD_W = 16;
    localparam int X_LSB = 16;
    localparam int Y_LSB = 0;
    localparam int NUM_POINTS = 5;
    localparam logic [7:0] TAG_NONE = 8'h00;
    localparam logic [15:0] COORD_RST = 16'h0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    // Tag index type
    typedef logic [2:0] mttr_idx_t;
endpackage : mttr_pkg

// [core/mttr_sync.sv]
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/100ps
`default_nettype none
module mttr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= i_d;
            q_r <= meta_r;
        end
    end
    assign o_q = q_r;
endmodule : mttr_sync
`default_nettype wire

// [core/mttr_edge.sv]
// Rising-edge pulse of a synchronised level
`timescale 1ns/100ps
`default_nettype none
module mttr_edge (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Level in, pulse out
    input wire logic i_lvl,
    output logic o_pulse
);
    logic prev_r;
    logic prev_nxt;
    always_comb begin
        prev_nxt = i_lvl;
    end
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end
    assign o_pulse = i_lvl & ~prev_r;
endmodule : mttr_edge
`default_nettype wire

// [core/mttr_regs.sv]
// Touch tag report bank: per-point tags and lookup coordinates
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module mttr_regs #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_SRST,
    // Register port
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    // Touch engine side
    input wire logic I_EXT_MODE,
    input wire logic I_FRAME_DONE,
    input wire logic [39:0] I_LOOKUP_TAG,
    input wire logic [79:0] I_LOOKUP_X,
    input wire logic [79:0] I_LOOKUP_Y,
    // Status
    output logic O_EXT_MODE,
    output logic O_FRAME_SEEN
);
    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    logic ext_mode_s;
    logic frame_done_s;
    logic frame_end;

    mttr_sync #(
        .W(2)
    ) u_sync (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_d({I_EXT_MODE, I_FRAME_DONE}),
        .o_q({ext_mode_s, frame_done_s})
    );

    // Scan-out end is a level from the display timer; act once per frame
    mttr_edge u_edge (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_lvl(frame_done_s),
        .o_pulse(frame_end)
    );

    // ****************************************************************
    // Tag and coordinate storage
    // ****************************************************************
    // Lookup results are assumed stable across the frame-end strobe,
    // since the engine publishes them before raising frame done.
    logic [mttr_pkg::TAG_W-1:0] tag_r [mttr_pkg::NUM_POINTS];
    logic [mttr_pkg::TAG_W-1:0] tag_nxt [mttr_pkg::NUM_POINTS];
    logic [mttr_pkg::COORD_W-1:0] x_r [mttr_pkg::NUM_POINTS];
    logic [mttr_pkg::COORD_W-1:0] x_nxt [mttr_pkg::NUM_POINTS];
    logic [mttr_pkg::COORD_W-1:0] y_r [mttr_pkg::NUM_POINTS];
    logic [mttr_pkg::COORD_W-1:0] y_nxt [mttr_pkg::NUM_POINTS];
    logic ext_r;
    logic ext_nxt;
    logic seen_r;
    logic seen_nxt;

    // Point is live: first always, second onward only in extended mode
    function automatic logic point_live(input int p, input logic ext);
        point_live = (p == 0) || ext;
    endfunction : point_live

    always_comb begin
        ext_nxt = ext_mode_s;
        seen_nxt = seen_r | frame_end;
        for (int p = 0; p < mttr_pkg::NUM_POINTS; p++) begin
            tag_nxt[p] = tag_r[p];
            x_nxt[p] = x_r[p];
            y_nxt[p] = y_r[p];
            if (frame_end) begin
                if (point_live(p, ext_r)) begin
                    // Zero passes through unchanged and means no touch
                    tag_nxt[p] = I_LOOKUP_TAG[p*8 +: 8];
                    x_nxt[p] = I_LOOKUP_X[p*16 +: 16];
                    y_nxt[p] = I_LOOKUP_Y[p*16 +: 16];
                end else begin
                    // Stale multi-point state is dropped outside ext mode
                    tag_nxt[p] = mttr_pkg::TAG_NONE;
                    x_nxt[p] = mttr_pkg::COORD_RST;
                    y_nxt[p] = mttr_pkg::COORD_RST;
                end
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            for (int p = 0; p < mttr_pkg::NUM_POINTS; p++) begin
                tag_r[p] <= mttr_pkg::TAG_NONE;
                x_r[p] <= mttr_pkg::COORD_RST;
                y_r[p] <= mttr_pkg::COORD_RST;
            end
            ext_r <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            for (int p = 0; p < mttr_pkg::NUM_POINTS; p++) begin
                tag_r[p] <= tag_nxt[p];
                x_r[p] <= x_nxt[p];
                y_r[p] <= y_nxt[p];
            end
            ext_r <= ext_nxt;
            seen_r <= seen_nxt;
        end
    end

    // ****************************************************************
    // Read decode
    // ****************************************************************
    function automatic logic [31:0] tag_word(
        input logic [mttr_pkg::TAG_W-1:0] t
    );
        tag_word = {24'h00_0000, t};
    endfunction : tag_word

    function automatic logic [31:0] xy_word(
        input logic [15:0] x,
        input logic [15:0] y
    );
        xy_word = 32'h0000_0000;
        xy_word[mttr_pkg::X_LSB +: 16] = x;
        xy_word[mttr_pkg::Y_LSB +: 16] = y;
    endfunction : xy_word

    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [11:0] a;

    always_comb begin
        a = 12'(I_ADDR);
        rdata_nxt = mttr_pkg::RDATA_RST;
        // Writes are ignored: the bank is read-only
        if (I_RD) begin
            if (a == mttr_pkg::OFF_FIRST_XY) begin
                rdata_nxt = xy_word(x_r[0], y_r[0]);
            end else if (a == mttr_pkg::OFF_FIRST_TAG) begin
                rdata_nxt = tag_word(tag_r[0]);
            end else if (a == mttr_pkg::OFF_SECOND_XY) begin
                rdata_nxt = xy_word(x_r[1], y_r[1]);
            end else if (a == mttr_pkg::OFF_SECOND_TAG) begin
                rdata_nxt = tag_word(tag_r[1]);
            end else if (a == mttr_pkg::OFF_THIRD_XY) begin
                rdata_nxt = xy_word(x_r[2], y_r[2]);
            end else if (a == mttr_pkg::OFF_THIRD_TAG) begin
                rdata_nxt = tag_word(tag_r[2]);
            end else if (a == mttr_pkg::OFF_FOURTH_XY) begin
                rdata_nxt = xy_word(x_r[3], y_r[3]);
            end else if (a == mttr_pkg::OFF_FOURTH_TAG) begin
                rdata_nxt = tag_word(tag_r[3]);
            end else if (a == mttr_pkg::OFF_FIFTH_XY) begin
                rdata_nxt = xy_word(x_r[4], y_r[4]);
            end else if (a == mttr_pkg::OFF_FIFTH_TAG) begin
                rdata_nxt = tag_word(tag_r[4]);
            end else begin
                // Unmapped offsets read zero
                rdata_nxt = mttr_pkg::RDATA_RST;
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            rdata_r <= mttr_pkg::RDATA_RST;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign O_RDATA = rdata_r;
    assign O_EXT_MODE = ext_r;
    assign O_FRAME_SEEN = seen_r;

    // Write data has no destination in a read-only bank
    logic unused_wr;
    assign unused_wr = I_WR ^ (^I_WDATA);

endmodule : mttr_regs
`default_nettype wire

// [dv/mttr_regs_assertions.sv]
// Checker: port-level properties of the tag report bank
`timescale 1ns/100ps
`default_nettype none
module mttr_regs_chk #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_SRST,
    // Register port
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [31:0] O_RDATA,
    // Engine side and status
    input wire logic I_EXT_MODE,
    input wire logic I_FRAME_DONE,
    input wire logic O_EXT_MODE,
    input wire logic O_FRAME_SEEN
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);
    sequence s_tag_read;
        I_RD && I_ADDR[2:0] == 3'h4;
    endsequence
    // Held long enough to pass the synchroniser
    sequence s_frame_rise;
        $rose(I_FRAME_DONE) ##1 I_FRAME_DONE [*4];
    endsequence
    a_idle_rdata_zero: assert property (!I_RD |=> O_RDATA == '0)
        else $error("read data not zero without a read");
    a_write_ignored: assert property (I_WR |=> O_RDATA == '0)
        else $error("write produced read data");
    a_tag_resv_zero: assert property (
        s_tag_read |=> O_RDATA[31:8] == '0)
        else $error("reserved tag bits not zero");
    a_low_unmapped: assert property (
        I_RD && I_ADDR < 12'h128 |=> O_RDATA == '0)
        else $error("unmapped read not zero");
    a_reset_all_zero: assert property (
        (I_RD && !O_FRAME_SEEN) ##1 !O_FRAME_SEEN |-> O_RDATA == '0)
        else $error("register not zero before first frame");
    a_frame_to_seen: assert property (s_frame_rise |-> O_FRAME_SEEN)
        else $error("frame end not taken");
    a_seen_sticky: assert property (O_FRAME_SEEN |=> O_FRAME_SEEN)
        else $error("frame seen flag dropped");
    // First flop took the pin three edges before the flag rose
    a_seen_needs_frame: assert property (
        $rose(O_FRAME_SEEN) |-> $past(I_FRAME_DONE, 3))
        else $error("frame seen without frame end");
    a_mode_rise: assert property (
        $rose(I_EXT_MODE) |-> ##[2:5] O_EXT_MODE)
        else $error("extended mode not taken");
    a_mode_fall: assert property (
        $fell(I_EXT_MODE) |-> ##[2:5] !O_EXT_MODE)
        else $error("compatibility mode not taken");
endmodule : mttr_regs_chk
bind mttr_regs mttr_regs_chk #(.ADDR_W(ADDR_W)) chk_u (.I_CLK(I_CLK),
    .I_SRST(I_SRST), .I_ADDR(I_ADDR), .I_WR(I_WR), .I_RD(I_RD),
    .O_RDATA(O_RDATA), .I_EXT_MODE(I_EXT_MODE), .I_FRAME_DONE(I_FRAME_DONE),
    .O_EXT_MODE(O_EXT_MODE), .O_FRAME_SEEN(O_FRAME_SEEN));
`default_nettype wire

// [dv/tb.sv]
// Testbench: register reads of the tag report bank across frames
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic I_CLK = 0, I_SRST = 1, I_WR = 0, I_RD = 0;
    logic I_EXT_MODE = 0, I_FRAME_DONE = 0;
    logic [11:0] I_ADDR = '0;
    logic [31:0] I_WDATA = '0, O_RDATA;
    logic [39:0] I_LOOKUP_TAG = '0;
    logic [79:0] I_LOOKUP_X = '0, I_LOOKUP_Y = '0;
    logic O_EXT_MODE, O_FRAME_SEEN;
    logic [31:0] exp_tag [5] = '{default: '0};
    logic [31:0] exp_xy [5];
    int error_cnt = 0, check_count = 0;
    always #2 I_CLK = ~I_CLK;
    mttr_regs dut_u (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_ADDR(I_ADDR),
        .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
        .I_EXT_MODE(I_EXT_MODE), .I_FRAME_DONE(I_FRAME_DONE),
        .I_LOOKUP_TAG(I_LOOKUP_TAG), .I_LOOKUP_X(I_LOOKUP_X),
        .I_LOOKUP_Y(I_LOOKUP_Y), .O_EXT_MODE(O_EXT_MODE),
        .O_FRAME_SEEN(O_FRAME_SEEN));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge I_CLK);
        I_ADDR <= a;
        I_RD <= 1'b1;
        @(posedge I_CLK);
        I_RD <= 1'b0;
        #1 chk(O_RDATA, exp);
    endtask : rd
    task automatic wr(input logic [11:0] a);
        @(posedge I_CLK);
        I_ADDR <= a;
        I_WDATA <= 32'hffff_ffff;
        I_WR <= 1'b1;
        @(posedge I_CLK);
        I_WR <= 1'b0;
    endtask : wr
    // Compat frames clear points two to five
    task automatic frame(input logic ext, input logic [7:0] s);
        @(posedge I_CLK);
        I_EXT_MODE <= ext;
        for (int p = 0; p < 5; p++) begin
            I_LOOKUP_TAG[8*p+:8] <= s + 8'(p);
            I_LOOKUP_X[16*p+:16] <= {s, 8'(p)};
            I_LOOKUP_Y[16*p+:16] <= {8'(p), ~s};
        end
        rd(12'h13c, exp_tag[2]);
        repeat (6) @(posedge I_CLK);
        chk({31'h0, O_EXT_MODE}, {31'h0, ext});
        I_FRAME_DONE <= 1'b1;
        repeat (8) @(posedge I_CLK);
        I_FRAME_DONE <= 1'b0;
        repeat (4) @(posedge I_CLK);
        for (int p = 0; p < 5; p++) begin
            exp_tag[p] = (ext || p == 0) ? {24'h0, s + 8'(p)} : '0;
            exp_xy[p] = (ext || p == 0) ? {s, 8'(p), 8'(p), ~s} : '0;
            rd(12'h128 + 12'(8 * p), exp_xy[p]);
            rd(12'h12c + 12'(8 * p), exp_tag[p]);
        end
    endtask : frame
    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // ****************************************************************
    // Sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (4) @(posedge I_CLK);
        I_SRST <= 1'b0;
        for (int p = 0; p < 10; p++) begin
            rd(12'h128 + 12'(4 * p), '0);
        end
        rd(12'h124, '0);
        rd(12'h150, '0);
        chk({31'h0, O_FRAME_SEEN}, 32'h0);
        chk({31'h0, O_EXT_MODE}, 32'h0);
        frame(1'b1, 8'hfb);
        wr(12'h13c);
        rd(12'h13c, exp_tag[2]);
        frame(1'b0, 8'h01);
        frame(1'b1, 8'h80);
        chk({31'h0, O_FRAME_SEEN}, 32'h1);
        end_of_test;
    end
    initial begin
        repeat (3000) @(posedge I_CLK);
        error_cnt++;
        end_of_test;
    end
endmodule : tb
`default_nettype wire
